// ===== logic/stereo_dac_front.sv
// serial input, latch and channel steering of a stereo integrating converter
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_front
  import dac_front_pkg::*;
#(
  parameter int WIDTH = WORD_BITS  // sample word width
) (
  input  wire logic CLOCK,                 // conversion master clock
  input  wire logic RST_N,                 // async reset, active low
  input  wire logic BIT_CLOCK,             // serial bit clock from source
  input  wire logic SERIAL_DATA,           // serial sample data
  input  wire logic WORD_CLOCK,            // word clock from source
  input  wire logic FRAME_STROBE,          // left/right frame strobe
  input  wire logic CONVERSION_COMMAND,    // timing reset command
  input  wire logic LATCH_CLOCK,           // retiming clock pin
  output var  logic CONV_CLOCK_OUT,        // clock drive, master divided by two
  output var  logic CHANNEL_SWITCH_DRIVE,  // analogue switch select
  output var  logic DISCHARGE_RIGHT,       // right discharge control
  output var  logic DISCHARGE_LEFT,        // left discharge control
  output var  logic INTEG_CURRENT_RIGHT,   // right integrate enable
  output var  logic INTEG_CURRENT_LEFT,    // left integrate enable
  output var  logic [WIDTH-1:0] SAMPLE_OUT,  // retimed sample
  output var  logic SAMPLE_LEFT            // channel of retimed sample
);
  // ************************************************
  // link domain: shift and word latch on bit clock
  // ************************************************
  logic [WIDTH-1:0] shift_q, shift_d;   // incoming bits
  logic [WIDTH-1:0] word_q, word_d;     // latched word
  logic             left_q, left_d;     // channel of latched word
  logic             wclk_q, wclk_d;     // word clock seen last edge
  logic             tog_q, tog_d;       // toggles per latched word

  // shift msb first; copy on word clock high-to-low
  always_comb begin
    shift_d = {shift_q[WIDTH-2:0], SERIAL_DATA};
    wclk_d  = WORD_CLOCK;
    word_d  = word_q;
    left_d  = left_q;
    tog_d   = tog_q;
    if (wclk_q && !WORD_CLOCK) begin
      word_d = shift_q;
      left_d = FRAME_STROBE;
      tog_d  = !tog_q;
    end
  end

  // registers of the link domain
  always_ff @(posedge BIT_CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      shift_q <= WORD_RESET;
      word_q  <= WORD_RESET;
      left_q  <= 1'b0;
      wclk_q  <= 1'b0;
      tog_q   <= 1'b0;
    end else begin
      shift_q <= shift_d;
      word_q  <= word_d;
      left_q  <= left_d;
      wclk_q  <= wclk_d;
      tog_q   <= tog_d;
    end
  end

  // ************************************************
  // crossings into the master clock domain
  // ************************************************
  logic tog_s;       // word event toggle, synchronised
  logic strobe_s;    // frame strobe, synchronised
  logic cc_s;        // conversion command, synchronised
  logic latch_s;     // latch clock pin, synchronised

  pin_sync #(.WIDTH(4)) u_sync (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .async_in ({tog_q, FRAME_STROBE, CONVERSION_COMMAND, LATCH_CLOCK}),
    .sync_out ({tog_s, strobe_s, cc_s, latch_s})
  );

  // ************************************************
  // master domain: word capture and retiming
  // ************************************************
  logic [WIDTH-1:0] held_q, held_d;    // word taken across
  logic             hleft_q, hleft_d;  // its channel
  logic             tseen_q;           // last toggle level seen
  logic             lprev_q;           // last latch pin level
  logic [WIDTH-1:0] out_q, out_d;      // retimed sample
  logic             oleft_q, oleft_d;  // retimed channel
  logic             load_evt;          // new retimed sample this cycle

  // word stands still for many bit clocks after the toggle, so is safe
  always_comb begin
    held_d   = held_q;
    hleft_d  = hleft_q;
    out_d    = out_q;
    oleft_d  = oleft_q;
    load_evt = 1'b0;
    if (tog_s != tseen_q) begin
      held_d  = word_q;
      hleft_d = left_q;
    end
    if (latch_s && !lprev_q) begin
      out_d    = held_q;
      oleft_d  = hleft_q;
      load_evt = 1'b1;
    end
  end

  // registers of capture and retiming
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      held_q  <= WORD_RESET;
      hleft_q <= 1'b0;
      tseen_q <= 1'b0;
      lprev_q <= 1'b0;
      out_q   <= WORD_RESET;
      oleft_q <= 1'b0;
    end else begin
      held_q  <= held_d;
      hleft_q <= hleft_d;
      tseen_q <= tog_s;
      lprev_q <= latch_s;
      out_q   <= out_d;
      oleft_q <= oleft_d;
    end
  end

  // ************************************************
  // conversion timing and command reset
  // ************************************************
  typedef enum {ST_IDLE, ST_INTEG, ST_DISCH} conv_state_t;
  conv_state_t      st_q, st_d;          // conversion phase
  logic [1:0]       cc_cnt_q, cc_cnt_d;  // command-high cycles
  logic             hold_q, hold_d;      // timing held in reset
  logic [RAMP_BITS-1:0] ramp_q, ramp_d;  // integrate down counter
  logic [7:0]       dis_q, dis_d;        // discharge down counter
  logic             clk_out_q, clk_out_d;  // clock drive divider

  // timing steps each master clock; command resets it
  always_comb begin
    cc_cnt_d = cc_s ? cc_cnt_q : CC_CNT_RESET;
    if (cc_s && cc_cnt_q != 2'(CC_HOLD_CYCLES))
      cc_cnt_d = cc_cnt_q + 2'h1;
    hold_d = hold_q;
    if (cc_s && cc_cnt_q == 2'(CC_HOLD_CYCLES - 1))
      hold_d = 1'b1;
    else if (!cc_s)
      hold_d = 1'b0;
    st_d   = st_q;
    ramp_d = ramp_q;
    dis_d  = dis_q;
    clk_out_d = !clk_out_q;                            // divide master by two
    case (st_q)
      ST_IDLE: begin
        if (load_evt) begin
          st_d   = ST_INTEG;
          ramp_d = out_d[WIDTH-1 -: RAMP_BITS];
        end
      end
      ST_INTEG: begin
        if (ramp_q == '0) begin
          st_d  = ST_DISCH;
          dis_d = 8'(DISCHARGE_CYC);
        end else begin
          ramp_d = ramp_q - 1'b1;
        end
      end
      ST_DISCH: begin
        dis_d = dis_q - 8'h01;
        if (dis_q == 8'h01)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (hold_q || hold_d) begin
      st_d   = ST_IDLE;
      ramp_d = '0;
      dis_d  = 8'h00;
    end
  end

  // registers of the timing
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q      <= ST_IDLE;
      cc_cnt_q  <= CC_CNT_RESET;
      hold_q    <= 1'b0;
      ramp_q    <= '0;
      dis_q     <= 8'h00;
      clk_out_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cc_cnt_q  <= cc_cnt_d;
      hold_q    <= hold_d;
      ramp_q    <= ramp_d;
      dis_q     <= dis_d;
      clk_out_q <= clk_out_d;
    end
  end

  // ************************************************
  // outputs and channel steering
  // ************************************************
  logic integ_on;  // integrate phase active
  logic dis_on;    // discharge phase active
  assign integ_on             = (st_q == ST_INTEG);
  assign dis_on               = (st_q == ST_DISCH);
  assign DISCHARGE_RIGHT      = dis_on && strobe_s;
  assign DISCHARGE_LEFT       = dis_on && !strobe_s;
  assign INTEG_CURRENT_RIGHT  = integ_on && strobe_s;
  assign INTEG_CURRENT_LEFT   = integ_on && !strobe_s;
  assign CHANNEL_SWITCH_DRIVE = strobe_s;
  assign CONV_CLOCK_OUT       = clk_out_q;
  assign SAMPLE_OUT           = out_q;
  assign SAMPLE_LEFT          = oleft_q;
endmodule : stereo_dac_front
`default_nettype wire

// ===== logic/dac_front_pkg.sv
// constants shared by the stereo converter serial front end
package dac_front_pkg;
  localparam int          WORD_BITS       = 16;          // bits per channel word
  localparam int          SYNC_STAGES     = 3;           // stages on an outside input, before the filter flop
  localparam int          CC_HOLD_CYCLES  = 3;           // least command-high length
  localparam int          CONV_CLOCK_MHZ  = 35;          // nominal conversion clock
  localparam int          CLOCK_KHZ       = 10_000;      // rate of the bench clock
  localparam int          DISCHARGE_NS    = 300;         // discharge pulse length
  localparam int          DISCHARGE_CYC   =
    (DISCHARGE_NS * CLOCK_KHZ + 999_999) / 1_000_000;    // rounded up, cycles
  localparam int          RAMP_BITS       = 6;           // integrate counter width
  localparam logic [15:0] WORD_RESET      = 16'h0000;    // latch value after reset
  localparam logic [1:0]  CC_CNT_RESET    = 2'h0;        // command counter reset
endpackage : dac_front_pkg

// ===== logic/pin_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1  // number of independent lanes
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  // ************************************************
  // per-lane stages
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic s1_q, s2_q, s3_q, out_q;  // stage chain and filtered level
      logic out_d;                    // next filtered level
      // filtered level moves only when stages 2 and 3 agree
      always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
      end
      // register the chain; stage 1 feeds stage 2 only
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q  <= async_in[g];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          out_q <= out_d;
        end
      end
      assign sync_out[g] = out_q;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// ===== test/serial_source.sv
// source model: frame strobe, word clock, bit clock and serial data
`timescale 1ns/1ps
`default_nettype none
module serial_source (
  output var logic bit_clock,
  output var logic serial_data,
  output var logic word_clock,
  output var logic frame_strobe
);
  // ****************************************
  // one channel word, bit clock only in frame
  // ****************************************
  initial begin
    bit_clock    = 1'b0;
    serial_data  = 1'b0;
    word_clock   = 1'b0;
    frame_strobe = 1'b0;
  end
  task automatic send_word(input logic [15:0] word, input logic left);
    frame_strobe = left;
    word_clock   = 1'b1;
    for (int i = 15; i >= -1; i--) begin
      if (i < 0) word_clock = 1'b0;
      serial_data = (i < 0) ? ~word[0] : word[i];
      #3 bit_clock = 1'b1;
      #3 bit_clock = 1'b0;
    end
  endtask : send_word
endmodule : serial_source
`default_nettype wire

// ===== test/stereo_dac_front_assertions.sv
// checker for steering, phases, command hold and retiming
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_front_assertions #(parameter int WIDTH = 16) (
  input wire logic             CLOCK,
  input wire logic             RST_N,
  input wire logic             FRAME_STROBE,
  input wire logic             CONVERSION_COMMAND,
  input wire logic             LATCH_CLOCK,
  input wire logic             CONV_CLOCK_OUT,
  input wire logic             CHANNEL_SWITCH_DRIVE,
  input wire logic             DISCHARGE_RIGHT,
  input wire logic             DISCHARGE_LEFT,
  input wire logic             INTEG_CURRENT_RIGHT,
  input wire logic             INTEG_CURRENT_LEFT,
  input wire logic [WIDTH-1:0] SAMPLE_OUT
);
  // ****************************************
  // properties on the conversion clock
  // ****************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic dis = DISCHARGE_LEFT | DISCHARGE_RIGHT;         // any discharge
  wire logic itg = INTEG_CURRENT_LEFT | INTEG_CURRENT_RIGHT; // any integrate
  AST_SWITCH_HIGH: assert property (FRAME_STROBE [*8] |-> CHANNEL_SWITCH_DRIVE)
    else $error("switch drive low under high strobe");
  AST_SWITCH_LOW: assert property (!FRAME_STROBE [*8] |-> !CHANNEL_SWITCH_DRIVE)
    else $error("switch drive high under low strobe");
  AST_HIGH_RIGHT: assert property (FRAME_STROBE [*8] |-> !DISCHARGE_LEFT && !INTEG_CURRENT_LEFT)
    else $error("left output active under high strobe");
  AST_LOW_LEFT: assert property (!FRAME_STROBE [*8] |-> !DISCHARGE_RIGHT && !INTEG_CURRENT_RIGHT)
    else $error("right output active under low strobe");
  AST_ONE_PHASE: assert property (!(dis && itg) && !(DISCHARGE_LEFT && DISCHARGE_RIGHT))
    else $error("phases or sides overlap");
  AST_DIS_LEN: assert property ($rose(dis) |-> dis [*3] ##1 !dis)
    else $error("discharge not three cycles");
  AST_CC_HOLD: assert property (CONVERSION_COMMAND [*8] |=> !dis && !itg)
    else $error("timing runs under command hold");
  AST_RETIME: assert property ($changed(SAMPLE_OUT) |-> $past(LATCH_CLOCK, 4))
    else $error("sample changed without latch clock");
  AST_CONV_CLOCK: assert property (CONV_CLOCK_OUT |=> !CONV_CLOCK_OUT)
    else $error("clock drive not divided");
  cover property ($rose(INTEG_CURRENT_RIGHT));
  cover property ($rose(INTEG_CURRENT_LEFT));
  cover property (CONVERSION_COMMAND [*8]);
endmodule : stereo_dac_front_assertions
bind stereo_dac_front stereo_dac_front_assertions #(.WIDTH(WIDTH)) u_chk (.CLOCK, .RST_N,
  .FRAME_STROBE, .CONVERSION_COMMAND, .LATCH_CLOCK, .CONV_CLOCK_OUT, .CHANNEL_SWITCH_DRIVE,
  .DISCHARGE_RIGHT, .DISCHARGE_LEFT, .INTEG_CURRENT_RIGHT, .INTEG_CURRENT_LEFT, .SAMPLE_OUT);
`default_nettype wire

// ===== test/tb_top.sv
// testbench: word capture, retiming, steering and command hold
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dac_front_pkg::*;
  logic        CLOCK = 1'b0;               // conversion clock
  logic        RST_N = 1'b0;               // reset, active low
  logic        CONVERSION_COMMAND = 1'b0;  // timing hold
  logic        LATCH_CLOCK = 1'b0;         // retiming pin
  logic        BIT_CLOCK, SERIAL_DATA, WORD_CLOCK, FRAME_STROBE, CONV_CLOCK_OUT;
  logic        CHANNEL_SWITCH_DRIVE, DISCHARGE_RIGHT, DISCHARGE_LEFT, SAMPLE_LEFT;
  logic        INTEG_CURRENT_RIGHT, INTEG_CURRENT_LEFT;
  logic [15:0] SAMPLE_OUT;                 // retimed word
  int          fails = 0, comparisons = 0, cycles = 0;
  serial_source u_src (.bit_clock(BIT_CLOCK), .serial_data(SERIAL_DATA),
    .word_clock(WORD_CLOCK), .frame_strobe(FRAME_STROBE));
  stereo_dac_front u_dut (.CLOCK, .RST_N, .BIT_CLOCK, .SERIAL_DATA, .WORD_CLOCK,
    .FRAME_STROBE, .CONVERSION_COMMAND, .LATCH_CLOCK, .CONV_CLOCK_OUT, .CHANNEL_SWITCH_DRIVE,
    .DISCHARGE_RIGHT, .DISCHARGE_LEFT, .INTEG_CURRENT_RIGHT, .INTEG_CURRENT_LEFT,
    .SAMPLE_OUT, .SAMPLE_LEFT);
  // ****************************************
  // clock, timeout, compares and verdict
  // ****************************************
  initial forever #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run;
    end
  end
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask : cmp_bit
  task automatic complete_run;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // two words back to back, latch, then time the integrate phase and check the discharge side
  task automatic t_word(input logic [15:0] w, input logic left);
    int n;
    u_src.send_word(~w, ~left);
    repeat (8) @(posedge CLOCK);  // first word must cross before the next one lands
    u_src.send_word(w, left);
    repeat (10) @(posedge CLOCK);
    LATCH_CLOCK <= 1'b1;
    n = 0;
    while ((INTEG_CURRENT_LEFT | INTEG_CURRENT_RIGHT) !== 1'b1 && n < 12) begin
      @(negedge CLOCK);
      n++;
    end
    cmp_word(SAMPLE_OUT, w, "sample word");
    cmp_bit(SAMPLE_LEFT, left, "sample channel");
    cmp_bit(INTEG_CURRENT_RIGHT, left, "integrate side");
    cmp_bit(INTEG_CURRENT_LEFT, ~left, "integrate other side");
    cmp_bit(CHANNEL_SWITCH_DRIVE, left, "switch drive");
    n = 0;
    while ((INTEG_CURRENT_LEFT | INTEG_CURRENT_RIGHT) === 1'b1 && n < 80) begin
      n++;
      @(negedge CLOCK);
    end
    cmp_word(16'(n), {10'h000, w[15:10]} + 16'h0001, "integrate length");
    cmp_bit(DISCHARGE_RIGHT, left, "discharge right");
    cmp_bit(DISCHARGE_LEFT, ~left, "discharge left");
    @(posedge CLOCK) LATCH_CLOCK <= 1'b0;
    repeat (8) @(posedge CLOCK);
  endtask : t_word
  // command held long: a latched word must not start a phase
  task automatic t_cmd;
    logic busy;  // any phase seen while held
    logic ph;    // clock drive level one cycle ago
    @(posedge CLOCK) CONVERSION_COMMAND <= 1'b1;
    u_src.send_word(16'h1234, 1'b0);
    repeat (10) @(posedge CLOCK);
    LATCH_CLOCK <= 1'b1;
    busy = 1'b0;
    // watch every cycle in which a free-running phase would have shown
    repeat (16) begin
      @(negedge CLOCK);
      busy = busy | INTEG_CURRENT_LEFT | INTEG_CURRENT_RIGHT;
      busy = busy | DISCHARGE_LEFT | DISCHARGE_RIGHT;
    end
    cmp_bit(busy, 1'b0, "timing idle in hold");
    ph = CONV_CLOCK_OUT;
    @(negedge CLOCK);
    cmp_bit(CONV_CLOCK_OUT, ~ph, "clock drive toggles");
    @(posedge CLOCK) LATCH_CLOCK <= 1'b0;
    CONVERSION_COMMAND <= 1'b0;
    repeat (8) @(posedge CLOCK);
  endtask : t_cmd
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    t_word(16'hA5C3, 1'b1);
    t_word(16'h03FF, 1'b0);
    t_word(16'hFC01, 1'b1);
    t_cmd;
    t_word(16'h8001, 1'b0);
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
